// ==== umsr_regs.svh ====
// register offsets, field positions and reset values of the modem status block
// assumes a 4-bit register address with 8-bit data
`ifndef UMSR_REGS_SVH
`define UMSR_REGS_SVH

// =====================================================
// register offsets
`define UMSR_ADDR_W 4
`define UMSR_OFF_IER 4'h1
`define UMSR_OFF_ISR_FCR 4'h2
`define UMSR_OFF_LCR 4'h3
`define UMSR_OFF_MCR 4'h4
`define UMSR_OFF_LSR 4'h5
`define UMSR_OFF_MSR 4'h6
`define UMSR_OFF_SPR 4'h7
`define UMSR_OFF_EVT 4'h8
`define UMSR_OFF_MASK 4'h9

// =====================================================
// reset values
`define UMSR_RST_ZERO 8'h00
`define UMSR_RST_ISR 8'h01
`define UMSR_RST_LSR 8'h60

// =====================================================
// field positions
`define UMSR_MCR_DTR 0
`define UMSR_MCR_RTS 1
`define UMSR_MCR_USER_OUTPUT_ONE 2
`define UMSR_MCR_USER_OUTPUT_TWO 3
`define UMSR_MCR_LOOP 4
`define UMSR_MCR_AFE 5
`define UMSR_IER_MODEM 3
`define UMSR_FCR_ENABLE 0

`endif

// ==== umsr_pkg.sv ====
// types shared by the modem status block
// assumes umsr_regs.svh supplies the numeric constants
package umsr_pkg;
  typedef logic [7:0] umsr_byte_type;
  // modem lines ordered carrier, ring, data-set-ready, clear-to-send
  typedef logic [3:0] umsr_lines_type;
endpackage : umsr_pkg

// ==== umsr_modem_status.sv ====
// modem status, modem control, scratch and reset-state registers of the uart
// assumes transmitter, receiver and fifos sit outside and trade status by ports
`timescale 1ns/1ps
`default_nettype none
`include "umsr_regs.svh"

module umsr_modem_status (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [`UMSR_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  // modem pins, active low
  input wire logic ctsPin_n,
  input wire logic dsrPin_n,
  input wire logic dcdPin_n,
  input wire logic riPin_n,
  output logic rtsPin_n,
  output logic dtrPin_n,
  output logic userOutputOne_n,
  output logic userOutputTwo_n,
  // transmitter and receiver status
  input wire logic txSerialIn,
  input wire logic txCharBusy,
  input wire logic rxDataAvail,
  input wire logic [6:1] lineStatusIn,
  input wire logic txReadyIn,
  input wire logic rxReadyIn,
  output logic txSerialOut,
  output logic txAllow,
  output logic transmitReadyOut_n,
  output logic receiveReadyOut_n,
  // interrupts
  output logic modemIrq,
  output logic irq
);

  // =====================================================
  // register map
  // 1 interrupt enable, bit 3 lets modem changes interrupt
  // 2 read: interrupt status view; write: fifo control
  // 3 line control, stored for the character logic outside
  // 4 modem control: 0 DTR, 1 RTS, 2 and 3 user outputs, 4 loopback, 5 flow control
  // 5 line status, refreshed every cycle from the receiver and transmitter
  // 6 modem_line_status: live lines on top, change flags below
  // 7 scratch_byte
  // 8 event status, write one to clear, same layout as the change flags
  // 9 event mask for the combined irq output
  // every other address reads zero and ignores writes
  //
  // read data is registered: it stands only in the cycle after the read strobe
  // and reads zero otherwise, so a late sample sees zero rather than stale data
  //
  // the change flags and the event status are set by the same change events;
  // they differ only in how they are cleared, by a status read or by a
  // write of ones, so software may use either without racing the other
  //
  // the status read clears the flags that it reports; an event in that very
  // cycle still sets its flag, so nothing is lost between read and clear
  //
  // the synchroniser costs two cycles of latency on every modem input;
  // a pin move reaches its flag on the third edge, the interrupt with it
  //
  // loopback swaps the status source to the control bits, which may itself
  // raise change flags; software should read the status once after a switch

  // =====================================================
  // helpers
  function automatic umsr_pkg::umsr_lines_type pinsToLines(input logic [3:0] pins_n);
    pinsToLines = ~pins_n;
  endfunction : pinsToLines

  function automatic logic isAccess(input logic stb, input logic [`UMSR_ADDR_W-1:0] a,
                                    input logic [`UMSR_ADDR_W-1:0] off);
    isAccess = stb && (a == off);
  endfunction : isAccess

  // =====================================================
  // registers
  umsr_pkg::umsr_byte_type ier_reg, lcr_reg, mcr_reg, fcr_reg, spr_reg, lsr_reg;
  umsr_pkg::umsr_byte_type rdData_reg;
  logic [3:0] flags_reg, flags_next;
  logic [3:0] evt_reg, evt_next, mask_reg;
  umsr_pkg::umsr_lines_type prevLines_reg;
  logic [3:0] sync1_reg, sync2_reg;
  logic txAllow_reg, txAllow_next;
  logic rts_reg, dtr_reg, user_output_one_reg, user_output_two_reg, txd_reg, transmit_ready_out_reg, receive_ready_out_reg;
  logic modemIrq_reg, irq_reg;

  // =====================================================
  // input synchroniser; data flops carry no reset so the upper status bits stay live
  always_ff @(posedge sys_clk) begin
    sync1_reg <= {dcdPin_n, riPin_n, dsrPin_n, ctsPin_n};
    sync2_reg <= sync1_reg;
  end

  // =====================================================
  // status selection and change detection
  wire loopOn = mcr_reg[`UMSR_MCR_LOOP];
  wire umsr_pkg::umsr_lines_type pinLines = pinsToLines(sync2_reg);
  wire umsr_pkg::umsr_lines_type loopLines = {mcr_reg[`UMSR_MCR_USER_OUTPUT_TWO],
                                              mcr_reg[`UMSR_MCR_USER_OUTPUT_ONE],
                                              mcr_reg[`UMSR_MCR_DTR],
                                              mcr_reg[`UMSR_MCR_RTS]};
  wire umsr_pkg::umsr_lines_type curLines = loopOn ? loopLines : pinLines;
  wire umsr_pkg::umsr_lines_type toggled = curLines ^ prevLines_reg;
  // ring flag only when the pin rises, i.e. the inverted status falls
  wire ringRise = prevLines_reg[2] && !curLines[2];
  wire [3:0] setEv = {toggled[3], ringRise, toggled[1], toggled[0]};

  wire wrHit = regWrStb;
  wire rdMsr = isAccess(regRdStb, regAddr, `UMSR_OFF_MSR);
  wire wrEvt = isAccess(wrHit, regAddr, `UMSR_OFF_EVT);

  // set wins over the clear of the same cycle
  assign flags_next = (rdMsr ? 4'h0 : flags_reg) | setEv;
  assign evt_next = (evt_reg & ~(wrEvt ? regWrData[3:0] : 4'h0)) | setEv;

  // =====================================================
  // flow control: decision only taken between characters
  // a character already started always finishes; the gate only moves
  // while the transmitter is idle, so a stop never cuts a frame short
  // the pin is read after the synchroniser, so the stop lags the pin
  // by three cycles, far below one bit time at any usable baud rate
  wire ctsPinHigh = sync2_reg[0];
  assign txAllow_next = txCharBusy ? txAllow_reg
                      : !(mcr_reg[`UMSR_MCR_AFE] && ctsPinHigh);

  // =====================================================
  // interrupt status and read mux
  // the status view shows live lines in the upper nibble and the
  // flags in the lower one; the flags are the registered ones, so the
  // value read is the one from before the clear of the same read
  wire modemPend = |flags_reg;
  wire isrPend = modemPend && ier_reg[`UMSR_IER_MODEM];
  wire umsr_pkg::umsr_byte_type isrView = {{2{fcr_reg[`UMSR_FCR_ENABLE]}}, 5'h00, !isrPend};
  wire umsr_pkg::umsr_byte_type msrView = {curLines, flags_reg};
  umsr_pkg::umsr_byte_type rdMux;
  always_comb begin
    case (regAddr)
      `UMSR_OFF_IER: rdMux = ier_reg;
      `UMSR_OFF_ISR_FCR: rdMux = isrView;
      `UMSR_OFF_LCR: rdMux = lcr_reg;
      `UMSR_OFF_MCR: rdMux = mcr_reg;
      `UMSR_OFF_LSR: rdMux = lsr_reg;
      `UMSR_OFF_MSR: rdMux = msrView;
      `UMSR_OFF_SPR: rdMux = spr_reg;
      `UMSR_OFF_EVT: rdMux = {4'h0, evt_reg};
      `UMSR_OFF_MASK: rdMux = {4'h0, mask_reg};
      default: rdMux = 8'h00;
    endcase
  end

  // =====================================================
  // software registers
  wire wrIer = isAccess(wrHit, regAddr, `UMSR_OFF_IER);
  wire wrFcr = isAccess(wrHit, regAddr, `UMSR_OFF_ISR_FCR);
  wire wrLcr = isAccess(wrHit, regAddr, `UMSR_OFF_LCR);
  wire wrMcr = isAccess(wrHit, regAddr, `UMSR_OFF_MCR);
  wire wrSpr = isAccess(wrHit, regAddr, `UMSR_OFF_SPR);
  wire wrMask = isAccess(wrHit, regAddr, `UMSR_OFF_MASK);

  // interrupt enable; only the modem bit acts here, the rest is kept for the host
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ier_reg <= `UMSR_RST_ZERO;
    end else if (wrIer) begin
      ier_reg <= regWrData;
    end
  end

  // fifo control is write-only; its enable bit shows in the status view
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fcr_reg <= `UMSR_RST_ZERO;
    end else if (wrFcr) begin
      fcr_reg <= regWrData;
    end
  end

  // line control is only stored for the character logic outside
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lcr_reg <= `UMSR_RST_ZERO;
    end else if (wrLcr) begin
      lcr_reg <= regWrData;
    end
  end

  // modem control: outputs, loopback and flow control enable
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mcr_reg <= `UMSR_RST_ZERO;
    end else if (wrMcr) begin
      mcr_reg <= regWrData;
    end
  end

  // scratch byte, no side effects
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      spr_reg <= `UMSR_RST_ZERO;
    end else if (wrSpr) begin
      spr_reg <= regWrData;
    end
  end

  // mask of the combined interrupt
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mask_reg <= 4'h0;
    end else if (wrMask) begin
      mask_reg <= regWrData[3:0];
    end
  end

  // =====================================================
  // status, flags and read data
  // change flags
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flags_reg <= 4'h0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // event status, cleared by writing ones
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      evt_reg <= 4'h0;
    end else begin
      evt_reg <= evt_next;
    end
  end

  // previous lines; reset to inactive, so a line other than ring already active at release flags once
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prevLines_reg <= 4'h0;
    end else begin
      prevLines_reg <= curLines;
    end
  end

  // line status copy
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lsr_reg <= `UMSR_RST_LSR;
    end else begin
      lsr_reg <= {1'b0, lineStatusIn, rxDataAvail};
    end
  end

  // read data, zero outside the answer cycle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= regRdStb ? rdMux : 8'h00;
    end
  end

  // =====================================================
  // pin outputs; loopback parks the modem outputs inactive and the line idle
  // request to send
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rts_reg <= 1'b1;
    end else begin
      rts_reg <= loopOn || !mcr_reg[`UMSR_MCR_RTS];
    end
  end

  // data terminal ready
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dtr_reg <= 1'b1;
    end else begin
      dtr_reg <= loopOn || !mcr_reg[`UMSR_MCR_DTR];
    end
  end

  // user_output_one
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      user_output_one_reg <= 1'b1;
    end else begin
      user_output_one_reg <= loopOn || !mcr_reg[`UMSR_MCR_USER_OUTPUT_ONE];
    end
  end

  // user_output_two
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      user_output_two_reg <= 1'b1;
    end else begin
      user_output_two_reg <= loopOn || !mcr_reg[`UMSR_MCR_USER_OUTPUT_TWO];
    end
  end

  // serial line; idle high in loopback so the far side sees no frame
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      txd_reg <= 1'b1;
    end else begin
      txd_reg <= loopOn || txSerialIn;
    end
  end

  // receive-ready output
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      receive_ready_out_reg <= 1'b1;
    end else begin
      receive_ready_out_reg <= !rxReadyIn;
    end
  end

  // transmit-ready output
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      transmit_ready_out_reg <= 1'b0;
    end else begin
      transmit_ready_out_reg <= !txReadyIn;
    end
  end

  // transmit gate
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      txAllow_reg <= 1'b1;
    end else begin
      txAllow_reg <= txAllow_next;
    end
  end

  // modem interrupt, from the next flags so it rises with them
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      modemIrq_reg <= 1'b0;
    end else begin
      modemIrq_reg <= |flags_next && ier_reg[`UMSR_IER_MODEM];
    end
  end

  // combined interrupt from the masked event status
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(evt_next & mask_reg);
    end
  end

  // =====================================================
  // outputs, each straight from its flip-flop

  assign regRdData = rdData_reg;
  assign rtsPin_n = rts_reg;
  assign dtrPin_n = dtr_reg;
  assign userOutputOne_n = user_output_one_reg;
  assign userOutputTwo_n = user_output_two_reg;
  assign txSerialOut = txd_reg;
  assign txAllow = txAllow_reg;
  assign transmitReadyOut_n = transmit_ready_out_reg;
  assign receiveReadyOut_n = receive_ready_out_reg;
  assign modemIrq = modemIrq_reg;
  assign irq = irq_reg;

endmodule : umsr_modem_status
`default_nettype wire

// ==== umsr_modem_model.sv ====
// far-side modem model driving the four handshake inputs
// assumes the bench sets the wanted line states each cycle
`timescale 1ns/1ps
`default_nettype none
module umsr_modem_model (
  // clock
  input wire logic sys_clk,
  // wanted states, high = asserted
  input wire umsr_pkg::umsr_lines_type want,
  // handshake pins, active low
  output var logic dcdPin_n = 1'b1,
  output var logic riPin_n = 1'b1,
  output var logic dsrPin_n = 1'b1,
  output var logic ctsPin_n = 1'b1
);
  // levels only; they move just after an edge, never mid-cycle
  always_ff @(posedge sys_clk) begin
    {dcdPin_n, riPin_n, dsrPin_n, ctsPin_n} <= ~want;
  end
endmodule : umsr_modem_model
`default_nettype wire

// ==== umsr_modem_status_properties.sv ====
// checker of the modem status block
// assumes it is bound to umsr_modem_status
`timescale 1ns/1ps
`default_nettype none
module umsr_modem_status_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regRdData,
  // pins and status
  input wire logic ctsPin_n,
  input wire logic dsrPin_n,
  input wire logic dcdPin_n,
  input wire logic riPin_n,
  input wire logic rtsPin_n,
  input wire logic dtrPin_n,
  input wire logic txSerialOut,
  input wire logic receiveReadyOut_n,
  input wire logic transmitReadyOut_n,
  input wire logic txCharBusy,
  input wire logic txAllow,
  input wire logic modemIrq
);
  // ==========
  // helpers
  logic [7:0] mcrReg;
  logic ier3Reg;
  logic [3:0] pinsReg;
  logic [2:0] quietReg;
  wire [3:0] pins = {dcdPin_n, riPin_n, dsrPin_n, ctsPin_n};
  wire mcrWr = regWrStb && regAddr == 4'h4;
  wire rdMsr = regRdStb && regAddr == 4'h6;
  // quiet: no pin move or mode write for seven cycles, so nothing is in flight
  wire quiet = quietReg == 3'h7 && pins == pinsReg;
  always_ff @(posedge sys_clk) begin
    pinsReg <= pins;
    if (!reset_n) begin
      mcrReg <= 8'h00;
      ier3Reg <= 1'b0;
      quietReg <= 3'h0;
    end else begin
      if (mcrWr) mcrReg <= regWrData;
      if (regWrStb && regAddr == 4'h1) ier3Reg <= regWrData[3];
      quietReg <= (pins != pinsReg || mcrWr) ? 3'h0 : quietReg + 3'(quietReg != 3'h7);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // assertions
  flags_clear_a: assert property (rdMsr ##1 rdMsr && quiet |=> regRdData[3:0] == 4'h0)
    else $error("change flags survived a status read");
  status_pins_a: assert property (rdMsr && quiet && !mcrReg[4] |=> regRdData[7:4] == ~$past(pins))
    else $error("status bits differ from pins");
  loop_status_a: assert property (rdMsr && quiet && mcrReg[4] |=> regRdData[7:4] == {mcrReg[3:2], mcrReg[0], mcrReg[1]})
    else $error("loopback status differs from control");
  change_irq_a: assert property (ier3Reg && !mcrReg[4] && $changed(dcdPin_n) ##0 !(regWrStb || regRdStb) [*5] |-> modemIrq)
    else $error("carrier change gave no interrupt");
  ring_fall_a: assert property (quietReg == 3'h7 && ier3Reg && !mcrReg[4] && !modemIrq && $fell(riPin_n)
    && $stable({dcdPin_n, dsrPin_n, ctsPin_n}) ##1 ($stable(pins) && !regWrStb) [*5] |-> !modemIrq)
    else $error("ring pin fall raised a flag");
  cts_stop_a: assert property ((mcrReg[5] && ctsPin_n) [*3] ##0 !txCharBusy |=> !txAllow)
    else $error("transmit not stopped by clear-to-send");
  busy_hold_a: assert property (txCharBusy |=> $stable(txAllow))
    else $error("transmit gate moved mid character");
  reset_outs_a: assert property (disable iff (1'b0) !reset_n ##1 !reset_n |-> rtsPin_n && dtrPin_n && txSerialOut
    && receiveReadyOut_n && !transmitReadyOut_n && !modemIrq)
    else $error("outputs wrong during reset");
  cover property (rdMsr && mcrReg[4]);
  cover property ($rose(modemIrq));
  cover property ($fell(txAllow));
endmodule : umsr_modem_status_props
bind umsr_modem_status umsr_modem_status_props u_umsr_modem_status_props (.sys_clk, .reset_n, .regAddr,
  .regWrData, .regWrStb, .regRdStb, .regRdData, .ctsPin_n, .dsrPin_n, .dcdPin_n, .riPin_n, .rtsPin_n, .dtrPin_n,
  .txSerialOut, .receiveReadyOut_n, .transmitReadyOut_n, .txCharBusy, .txAllow, .modemIrq);
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench of the modem status block
// assumes design, checker and modem model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic txCharBusy = 1'b0;
  logic rxDataAvail = 1'b0;
  umsr_pkg::umsr_lines_type want = 4'h0;
  logic [7:0] regRdData;
  logic ctsPin_n, dsrPin_n, dcdPin_n, riPin_n, rtsPin_n, dtrPin_n, userOutputOne_n, userOutputTwo_n;
  logic txSerialOut, txAllow, transmitReadyOut_n, receiveReadyOut_n, modemIrq, irq;
  int errorCnt = 0;
  int nCompared = 0;
  logic [3:0] wv [5] = '{4'hC, 4'h8, 4'hA, 4'hB, 4'h3};
  logic [7:0] ev [5] = '{8'hC0, 8'h84, 8'hA2, 8'hB1, 8'h38};
  logic [7:0] rv [7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00};
  always #4 sys_clk = ~sys_clk;
  umsr_modem_status u_umsr_modem_status (.sys_clk, .reset_n, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData, .ctsPin_n, .dsrPin_n, .dcdPin_n, .riPin_n, .rtsPin_n, .dtrPin_n, .userOutputOne_n,
    .userOutputTwo_n, .txSerialIn(1'b0), .txCharBusy, .rxDataAvail, .lineStatusIn(6'h30), .txReadyIn(1'b1),
    .rxReadyIn(1'b0), .txSerialOut, .txAllow, .transmitReadyOut_n, .receiveReadyOut_n, .modemIrq, .irq);
  umsr_modem_model u_umsr_modem_model (.sys_clk, .want, .dcdPin_n, .riPin_n, .dsrPin_n, .ctsPin_n);
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    nCompared++;
    if (s !== e) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask : wr
  // two = back-to-back pair; only the second answer is compared
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input bit two = 1'b0);
    @(posedge sys_clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    if (two) @(posedge sys_clk);
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 chk("regRdData", regRdData, e);
  endtask : rd
  task automatic conclude;
    $display("compared %0d errors %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) rd(4'(i + 1), rv[i]);
    wr(4'h7, 8'hA5);
    rd(4'h7, 8'hA5);
    rd(4'hF, 8'h00);
    wr(4'h1, 8'h08);
    @(posedge sys_clk) want <= 4'h8;
    repeat (6) @(posedge sys_clk);
    #1 chk("modemIrq", 8'(modemIrq), 8'h01);
    chk("irq", 8'(irq), 8'h00);
    rd(4'h2, 8'h00);
    wr(4'h9, 8'h0F);
    @(posedge sys_clk);
    #1 chk("irq", 8'(irq), 8'h01);
    rd(4'h6, 8'h80, 1'b1);
    chk("modemIrq", 8'(modemIrq), 8'h00);
    wr(4'h8, 8'h08);
    rd(4'h8, 8'h00);
    chk("irq", 8'(irq), 8'h00);
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk) want <= wv[i];
      repeat (6) @(posedge sys_clk);
      rd(4'h6, ev[i]);
    end
    wr(4'h4, 8'h15);
    repeat (8) @(posedge sys_clk);
    rd(4'h6, 8'h60, 1'b1);
    wr(4'h4, 8'h1A);
    repeat (8) @(posedge sys_clk);
    rd(4'h6, 8'h90, 1'b1);
    chk("pins", 8'({rtsPin_n, dtrPin_n, userOutputOne_n, userOutputTwo_n, txSerialOut}), 8'h1F);
    wr(4'h4, 8'h0B);
    @(posedge sys_clk);
    #1 chk("pins", 8'({rtsPin_n, dtrPin_n, userOutputOne_n, userOutputTwo_n, txSerialOut}), 8'h04);
    wr(4'h4, 8'h20);
    txCharBusy <= 1'b1;
    want <= 4'h2;
    repeat (6) @(posedge sys_clk);
    #1 chk("txAllow", 8'(txAllow), 8'h01);
    @(posedge sys_clk) txCharBusy <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 chk("txAllow", 8'(txAllow), 8'h00);
    @(posedge sys_clk) rxDataAvail <= 1'b1;
    rd(4'h5, 8'h61);
    @(posedge sys_clk) reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(4'h4, 8'h00);
    rd(4'h6, 8'h20, 1'b1);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
